// file: vss_dev.sv
// Purpose: oscillator subsystem write-only register bank and control decode
// Assumes: host keeps forwarding word layout and subsystem id zero
// Notes: outputs load one edge after the register that steers them
// Operation
// RQ1 - subsystem written only through forwarding register
// RQ2 - id, address, data packed at fixed positions
// RQ3 - subsystem id zero selects oscillator bank
// RQ4 - cal bit swaps tune for compensated voltage
// RQ5 - eight-bit sub-band, default sixteen
// RQ6 - master enable gates all, overrides auto
// RQ7 - manual enables for four blocks, default one
// RQ8 - divide ratio: zero mute, one direct, even N
// RQ9 - odd ratio rounds down, above 62 clamps
// RQ10 - auto mode enables follow divide ratio
// RQ11 - manual mode ignores divide ratio lsb
// RQ12 - two-bit RF output buffer gain, default 3
// RQ13 - divider stage gain bit, software picks by ratio
// RQ14 - config bit zero selects fundamental or doubler
// RQ15 - config bit two selects auto or manual
// RQ16 - software sets RF buffer bias by band
// RQ17 - software writes fixed bias and cal presets
// RQ18 - write-only, whole nine bits replaced each write
//
// The AXI4-Lite register port was chosen for this implementation.
module vss_dev (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  vss_link_if.dev link,
  output logic cal_voltage_sel,
  output logic [7:0] oscillator_subband_select,
  output logic subsystem_en,
  output logic pll_buf_en,
  output logic rf_buf_en,
  output logic div1_en,
  output logic rf_div_en,
  output logic output_mute,
  output logic [5:0] div_ratio,
  output logic [1:0] rf_out_gain,
  output logic div_out_gain,
  output logic fundamental_mode,
  output logic manual_output_enable_mode,
  output logic [1:0] rf_buf_bias,
  output logic [2:0] osc_bias,
  output logic [1:0] pll_buf_bias,
  output logic [1:0] fundamental_limiter_bias,
  output logic [1:0] preset_cal,
  output logic [1:0] cal_freq_low,
  output logic [1:0] cal_freq_mid_low,
  output logic [1:0] cal_freq_mid_high,
  output logic [1:0] cal_freq_high,
  output logic [7:0] msb_cal
);

  // ==========================================================
  // functions
  // ==========================================================
  function automatic logic [8:0] reset_value(input int idx);
    logic [8:0] v;
    v = vss_pkg::RST_TUNING;
    unique case (idx)
      1: v = vss_pkg::RST_ENABLES;
      2: v = vss_pkg::RST_DIVIDE;
      3: v = vss_pkg::RST_CONFIG;
      4: v = vss_pkg::RST_BIAS;
      5: v = vss_pkg::RST_CALFREQ;
      6: v = vss_pkg::RST_MSBCAL;
      default: v = vss_pkg::RST_TUNING;
    endcase
    return v;
  endfunction

  // manual mode drops the lsb, so only even ratios or mute remain
  function automatic logic [5:0] eff_ratio(input logic [5:0] r,
                                           input logic manual);
    logic [5:0] v;
    v = r;
    if (manual) begin
      v = {r[5:1], 1'b0}; // see RQ11
    end else if (r > vss_pkg::RATIO_MAX) begin
      v = vss_pkg::RATIO_MAX; // see RQ9
    end else if (r > vss_pkg::RATIO_ONE && r[0]) begin
      v = {r[5:1], 1'b0}; // see RQ9
    end
    return v;
  endfunction

  // ==========================================================
  // forwarding decode
  // ==========================================================
  logic [8:0] regs [vss_pkg::NUM_REGS];

  wire fwd_hit;
  wire id_match;
  wire [3:0] sub_addr;
  wire [8:0] sub_data;
  wire addr_ok;
  wire reg_we;

  assign fwd_hit = link.wr_en &&
                   (link.wr_addr == vss_pkg::FWD_REG_ADDR); // see RQ1
  assign id_match = link.wr_data[vss_pkg::ID_LSB +: vss_pkg::ID_W] ==
                    vss_pkg::SUBSYS_ID; // see RQ3
  assign sub_addr =
    link.wr_data[vss_pkg::SUBADDR_LSB +: vss_pkg::SUBADDR_W]; // see RQ2
  assign sub_data =
    link.wr_data[vss_pkg::DATA_LSB +: vss_pkg::DATA_W]; // see RQ2
  assign addr_ok = sub_addr <= vss_pkg::REG_MSBCAL;
  assign reg_we = fwd_hit && id_match && addr_ok;

  // whole word replaced, no read path back to the host
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < vss_pkg::NUM_REGS; i++) begin
        regs[i] <= reset_value(i);
      end
    end else if (ce && reg_we) begin
      regs[sub_addr[2:0]] <= sub_data; // see RQ18
    end
  end

  // ==========================================================
  // field views
  // ==========================================================
  wire [8:0] r_tune;
  wire [8:0] r_en;
  wire [8:0] r_div;
  wire [8:0] r_cfg;
  wire [8:0] r_bias;
  wire [8:0] r_cf;
  wire [8:0] r_msb;
  wire master;
  wire manual;
  wire [5:0] ratio;

  assign r_tune = regs[vss_pkg::REG_TUNING[2:0]];
  assign r_en = regs[vss_pkg::REG_ENABLES[2:0]];
  assign r_div = regs[vss_pkg::REG_DIVIDE[2:0]];
  assign r_cfg = regs[vss_pkg::REG_CONFIG[2:0]];
  assign r_bias = regs[vss_pkg::REG_BIAS[2:0]];
  assign r_cf = regs[vss_pkg::REG_CALFREQ[2:0]];
  assign r_msb = regs[vss_pkg::REG_MSBCAL[2:0]];
  assign master = r_en[vss_pkg::MASTER_BIT];
  assign manual = r_cfg[vss_pkg::MANUAL_BIT]; // see RQ15
  assign ratio = eff_ratio(r_div[vss_pkg::RATIO_LSB +: vss_pkg::RATIO_W],
                           manual); // see RQ8

  // ==========================================================
  // enable decode
  // ==========================================================
  wire auto_mute;
  wire auto_direct;
  wire auto_divided;
  wire next_pll_buf_en;
  wire next_rf_buf_en;
  wire next_div1_en;
  wire next_rf_div_en;

  assign auto_mute = ratio == vss_pkg::RATIO_MUTE;
  assign auto_direct = ratio == vss_pkg::RATIO_ONE;
  assign auto_divided = !auto_mute && !auto_direct;

  // auto mode: pll buffer stays on, rf stages follow ratio
  assign next_pll_buf_en = master &&
    (manual ? r_en[vss_pkg::PLLBUF_BIT] : 1'b1); // see RQ6 RQ7 RQ8
  assign next_rf_buf_en = master &&
    (manual ? r_en[vss_pkg::RFBUF_BIT] : !auto_mute); // see RQ10 RQ7
  assign next_div1_en = master &&
    (manual ? r_en[vss_pkg::DIV1_BIT] : auto_direct); // see RQ10 RQ7
  assign next_rf_div_en = master &&
    (manual ? r_en[vss_pkg::RFDIV_BIT] : auto_divided); // see RQ10 RQ7

  // ==========================================================
  // output flops
  // ==========================================================
  // outputs stay off with output_mute set during reset; defaults show one edge after release
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cal_voltage_sel <= 1'b0;
      oscillator_subband_select <= 8'h00;
      subsystem_en <= 1'b0;
      pll_buf_en <= 1'b0;
      rf_buf_en <= 1'b0;
      div1_en <= 1'b0;
      rf_div_en <= 1'b0;
      output_mute <= 1'b1;
      div_ratio <= 6'h00;
      rf_out_gain <= 2'h0;
      div_out_gain <= 1'b0;
      fundamental_mode <= 1'b0;
      manual_output_enable_mode <= 1'b0;
      rf_buf_bias <= 2'h0;
      osc_bias <= 3'h0;
      pll_buf_bias <= 2'h0;
      fundamental_limiter_bias <= 2'h0;
      preset_cal <= 2'h0;
      cal_freq_low <= 2'h0;
      cal_freq_mid_low <= 2'h0;
      cal_freq_mid_high <= 2'h0;
      cal_freq_high <= 2'h0;
      msb_cal <= 8'h00;
    end else if (ce) begin
      cal_voltage_sel <= r_tune[vss_pkg::CAL_BIT]; // see RQ4
      oscillator_subband_select <=
        r_tune[vss_pkg::SUBBAND_LSB +: vss_pkg::SUBBAND_W]; // see RQ5
      subsystem_en <= master; // see RQ6
      pll_buf_en <= next_pll_buf_en;
      rf_buf_en <= next_rf_buf_en;
      div1_en <= next_div1_en;
      rf_div_en <= next_rf_div_en;
      output_mute <= !next_rf_buf_en; // see RQ8
      div_ratio <= ratio; // see RQ9
      rf_out_gain <= r_div[vss_pkg::RF_GAIN_LSB +: 2]; // see RQ12
      div_out_gain <= r_div[vss_pkg::DIV_GAIN_BIT]; // see RQ13
      fundamental_mode <= r_cfg[vss_pkg::FUND_BIT]; // see RQ14
      manual_output_enable_mode <= manual; // see RQ15
      rf_buf_bias <= r_cfg[vss_pkg::RFBIAS_LSB +: 2];
      osc_bias <= r_bias[vss_pkg::OSC_BIAS_LSB +: vss_pkg::OSC_BIAS_W];
      pll_buf_bias <= r_bias[vss_pkg::PLLB_BIAS_LSB +: 2];
      fundamental_limiter_bias <= r_bias[vss_pkg::LIM_BIAS_LSB +: 2];
      preset_cal <= r_bias[vss_pkg::PRESET_CAL_LSB +: 2];
      cal_freq_low <= r_cf[vss_pkg::CF_LOW_LSB +: 2];
      cal_freq_mid_low <= r_cf[vss_pkg::CF_MID_LOW_LSB +: 2];
      cal_freq_mid_high <= r_cf[vss_pkg::CF_MID_HIGH_LSB +: 2];
      cal_freq_high <= r_cf[vss_pkg::CF_HIGH_LSB +: 2];
      msb_cal <= r_msb[vss_pkg::MSB_FIELDS_W-1:0];
    end
  end

endmodule

// file: vss_pkg.sv
// Purpose: shared constants for the oscillator subsystem register bank
// Assumes: one clock, synchronous active-low reset
// Notes: forwarding word layout, subsystem map, host register map
package vss_pkg;

  // ==========================================================
  // main serial port and forwarding word
  // ==========================================================
  localparam int MAIN_ADDR_W = 6;
  localparam int MAIN_DATA_W = 24;
  localparam logic [5:0] FWD_REG_ADDR = 6'h05;
  localparam int ID_LSB = 0;
  localparam int ID_W = 3;
  localparam int SUBADDR_LSB = 3;
  localparam int SUBADDR_W = 4;
  localparam int DATA_LSB = 7;
  localparam int DATA_W = 9;
  localparam logic [2:0] SUBSYS_ID = 3'h0;

  // ==========================================================
  // subsystem register addresses
  // ==========================================================
  localparam int NUM_REGS = 7;
  localparam logic [3:0] REG_TUNING = 4'h0;
  localparam logic [3:0] REG_ENABLES = 4'h1;
  localparam logic [3:0] REG_DIVIDE = 4'h2;
  localparam logic [3:0] REG_CONFIG = 4'h3;
  localparam logic [3:0] REG_BIAS = 4'h4;
  localparam logic [3:0] REG_CALFREQ = 4'h5;
  localparam logic [3:0] REG_MSBCAL = 4'h6;

  // ==========================================================
  // reset values
  // ==========================================================
  localparam logic [8:0] RST_TUNING = 9'h020;
  localparam logic [8:0] RST_ENABLES = 9'h01F;
  localparam logic [8:0] RST_DIVIDE = 9'h0C1;
  localparam logic [8:0] RST_CONFIG = 9'h051;
  localparam logic [8:0] RST_BIAS = 9'h0C9;
  localparam logic [8:0] RST_CALFREQ = 9'h0AA;
  localparam logic [8:0] RST_MSBCAL = 9'h0FF;

  // ==========================================================
  // field positions
  // ==========================================================
  localparam int CAL_BIT = 0;
  localparam int SUBBAND_LSB = 1;
  localparam int SUBBAND_W = 8;
  localparam int MASTER_BIT = 0;
  localparam int PLLBUF_BIT = 1;
  localparam int RFBUF_BIT = 2;
  localparam int DIV1_BIT = 3;
  localparam int RFDIV_BIT = 4;
  localparam int RATIO_LSB = 0;
  localparam int RATIO_W = 6;
  localparam int RF_GAIN_LSB = 6;
  localparam int DIV_GAIN_BIT = 8;
  localparam int FUND_BIT = 0;
  localparam int MANUAL_BIT = 2;
  localparam int RFBIAS_LSB = 3;
  localparam int OSC_BIAS_LSB = 0;
  localparam int OSC_BIAS_W = 3;
  localparam int PLLB_BIAS_LSB = 3;
  localparam int LIM_BIAS_LSB = 5;
  localparam int PRESET_CAL_LSB = 7;
  localparam int CF_LOW_LSB = 0;
  localparam int CF_MID_LOW_LSB = 2;
  localparam int CF_MID_HIGH_LSB = 4;
  localparam int CF_HIGH_LSB = 6;
  localparam int MSB_FIELDS_W = 8;
  localparam logic [5:0] RATIO_MUTE = 6'h00;
  localparam logic [5:0] RATIO_ONE = 6'h01;
  localparam logic [5:0] RATIO_MAX = 6'h3E;

  // ==========================================================
  // host register map (AXI4-Lite)
  // ==========================================================
  localparam logic [31:0] HOST_SUBADDR_OFF = 32'h0000_0000;
  localparam logic [31:0] HOST_DATA_OFF = 32'h0000_0004;
  localparam logic [31:0] HOST_COUNT_OFF = 32'h0000_0008;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] DATA_STRB = 2'h3;

  function automatic logic [23:0] pack_fwd(input logic [3:0] sub,
                                           input logic [8:0] data);
    logic [23:0] w;
    w = 24'h000000;
    w[ID_LSB +: ID_W] = SUBSYS_ID;
    w[SUBADDR_LSB +: SUBADDR_W] = sub;
    w[DATA_LSB +: DATA_W] = data;
    return w;
  endfunction

endpackage

// file: vss_link_if.sv
// Purpose: main serial port register write path between host and device
// Assumes: wr_en is a one-cycle pulse on aclk
// Notes: no readback of subsystem registers exists
interface vss_link_if;
  logic wr_en;
  logic [5:0] wr_addr;
  logic [23:0] wr_data;

  modport host (
    output wr_en,
    output wr_addr,
    output wr_data
  );

  modport dev (
    input wr_en,
    input wr_addr,
    input wr_data
  );
endinterface

// file: vss_host.sv
// Purpose: AXI4-Lite front end that forwards subsystem writes
// Assumes: one outstanding write and one read at a time
// Notes: a data write with both low byte strobes set fires one forwarding pulse on the link
module vss_host (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  vss_link_if.host link,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ==========================================================
  // write channel decode
  // ==========================================================
  logic [31:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic aw_held;
  logic w_held;
  logic [3:0] sub_addr;
  logic [8:0] last_data;
  logic [15:0] fwd_count;

  wire aw_take;
  wire w_take;
  wire do_write;
  wire hit_sub;
  wire hit_data;
  wire hit_count;
  wire data_full;
  wire fire;

  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign hit_sub = aw_addr == vss_pkg::HOST_SUBADDR_OFF;
  assign hit_data = aw_addr == vss_pkg::HOST_DATA_OFF;
  assign hit_count = aw_addr == vss_pkg::HOST_COUNT_OFF;
  assign data_full = w_strb[1:0] == vss_pkg::DATA_STRB;
  // partial strobes would leave stale bits, so they are not forwarded
  assign fire = do_write && hit_data && data_full; // see RQ18

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 32'h0000_0000;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= vss_pkg::RESP_OKAY;
    end else if (ce) begin
      if (aw_take) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (w_take) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (hit_sub || hit_data || hit_count) ?
                       vss_pkg::RESP_OKAY : vss_pkg::RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // ==========================================================
  // own registers and link drive
  // ==========================================================
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sub_addr <= 4'h0;
      last_data <= 9'h000;
      fwd_count <= 16'h0000;
      link.wr_en <= 1'b0;
      link.wr_addr <= 6'h00;
      link.wr_data <= 24'h000000;
    end else if (ce) begin
      link.wr_en <= fire;
      if (do_write && hit_sub && w_strb[0]) begin
        sub_addr <= w_data[3:0];
      end
      if (fire) begin
        last_data <= w_data[8:0];
        fwd_count <= fwd_count + 16'h0001;
        link.wr_addr <= vss_pkg::FWD_REG_ADDR; // see RQ1
        link.wr_data <=
          vss_pkg::pack_fwd(sub_addr, w_data[8:0]); // see RQ2 RQ3
      end
    end
  end

  // ==========================================================
  // read channel
  // ==========================================================
  wire [31:0] rd_value;
  wire rd_hit;

  assign rd_hit = s_axi_araddr == vss_pkg::HOST_SUBADDR_OFF ||
                  s_axi_araddr == vss_pkg::HOST_DATA_OFF ||
                  s_axi_araddr == vss_pkg::HOST_COUNT_OFF;
  assign rd_value =
    (s_axi_araddr == vss_pkg::HOST_SUBADDR_OFF) ? {28'h0, sub_addr} :
    (s_axi_araddr == vss_pkg::HOST_DATA_OFF) ? {23'h0, last_data} :
    (s_axi_araddr == vss_pkg::HOST_COUNT_OFF) ? {16'h0, fwd_count} :
    32'h0000_0000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= vss_pkg::RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_value;
        s_axi_rresp <= rd_hit ? vss_pkg::RESP_OKAY : vss_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule

// file: vss_link_props.sv
// Purpose: link and output checks for the subsystem register bank
// Assumes: one aclk domain, aresetn synchronous active low
// Notes: dev outputs settle one edge after the register write
module vss_link_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic wr_en,
  input wire logic [5:0] wr_addr,
  input wire logic [23:0] wr_data,
  input wire logic cal_voltage_sel,
  input wire logic [7:0] oscillator_subband_select,
  input wire logic subsystem_en,
  input wire logic pll_buf_en,
  input wire logic rf_buf_en,
  input wire logic div1_en,
  input wire logic rf_div_en,
  input wire logic output_mute,
  input wire logic [5:0] div_ratio,
  input wire logic manual_output_enable_mode,
  input wire logic [2:0] osc_bias,
  input wire logic [1:0] preset_cal
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // ==========================================================
  // forwarding writes
  // ==========================================================
  sequence s_fwd(logic [3:0] sa);
    ce && wr_en && wr_addr == vss_pkg::FWD_REG_ADDR &&
    wr_data[2:0] == 3'h0 && wr_data[6:3] == sa;
  endsequence

  a_link_addr: assert property (
    wr_en |-> wr_addr == 6'h05) else $error("link address not 05");
  a_link_id: assert property (
    wr_en |-> wr_data[2:0] == 3'h0) else $error("link id not zero");
  a_link_pad: assert property (
    wr_en |-> wr_data[23:16] == 8'h00) else $error("link pad bits set");
  a_tune_load: assert property (
    s_fwd(4'h0) ##1 ce |=> cal_voltage_sel == $past(wr_data[7], 2) &&
    oscillator_subband_select == $past(wr_data[15:8], 2))
    else $error("tuning write not applied");
  a_bias_load: assert property (
    s_fwd(4'h4) ##1 ce |=> osc_bias == $past(wr_data[9:7], 2) &&
    preset_cal == $past(wr_data[15:14], 2))
    else $error("bias write not applied");

  // ==========================================================
  // enables and ratio
  // ==========================================================
  a_mute_inverse: assert property (
    output_mute != rf_buf_en) else $error("mute not inverse of rf buffer");
  a_master_off: assert property (
    !subsystem_en |-> !(pll_buf_en || rf_buf_en || div1_en || rf_div_en))
    else $error("enable on with master off");
  a_ratio_legal: assert property (
    div_ratio <= 6'h3E && (div_ratio <= 6'h01 || !div_ratio[0]))
    else $error("illegal effective ratio");
  a_manual_lsb: assert property (
    manual_output_enable_mode |-> div_ratio != 6'h01)
    else $error("ratio lsb used in manual mode");
  a_auto_enables: assert property (
    subsystem_en && !manual_output_enable_mode |->
    rf_buf_en == (div_ratio != 6'h00) && div1_en == (div_ratio == 6'h01) &&
    rf_div_en == (div_ratio > 6'h01)) else $error("auto enables wrong");
endmodule

// file: tb_vco_subsystem_indirect_regs.sv
// Purpose: self-checking bench, host and device joined over the link
// Assumes: AXI4-Lite master in tasks, ce held high
// Notes: outputs checked three edges after the data write response
module tb_vco_subsystem_indirect_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, ce;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic cal_voltage_sel, subsystem_en, pll_buf_en, rf_buf_en, div1_en;
  logic rf_div_en, output_mute, div_out_gain, fundamental_mode;
  logic manual_output_enable_mode;
  logic [7:0] oscillator_subband_select, msb_cal;
  logic [5:0] div_ratio;
  logic [2:0] osc_bias;
  logic [1:0] rf_out_gain, rf_buf_bias, pll_buf_bias, fundamental_limiter_bias;
  logic [1:0] preset_cal, cal_freq_low, cal_freq_mid_low, cal_freq_mid_high;
  logic [1:0] cal_freq_high;
  int err_total, comparisons;
  wire [3:0] en4 = {pll_buf_en, rf_buf_en, div1_en, rf_div_en};
  wire [8:0] tune9 = {oscillator_subband_select, cal_voltage_sel};
  wire [3:0] cfg4 = {manual_output_enable_mode, fundamental_mode, rf_buf_bias};
  wire [8:0] bias9 = {preset_cal, fundamental_limiter_bias, pll_buf_bias,
    osc_bias};

  vss_link_if link_if ();
  vss_host vss_host_inst (.aclk, .aresetn, .ce, .link(link_if),
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);
  vss_dev vss_dev_inst (.aclk, .aresetn, .ce, .link(link_if),
    .cal_voltage_sel, .oscillator_subband_select, .subsystem_en,
    .pll_buf_en, .rf_buf_en, .div1_en, .rf_div_en, .output_mute,
    .div_ratio, .rf_out_gain, .div_out_gain, .fundamental_mode,
    .manual_output_enable_mode, .rf_buf_bias, .osc_bias, .pll_buf_bias,
    .fundamental_limiter_bias, .preset_cal, .cal_freq_low,
    .cal_freq_mid_low, .cal_freq_mid_high, .cal_freq_high, .msb_cal);
  vss_link_props vss_link_props_inst (.aclk, .aresetn, .ce,
    .wr_en(link_if.wr_en), .wr_addr(link_if.wr_addr),
    .wr_data(link_if.wr_data), .cal_voltage_sel, .oscillator_subband_select,
    .subsystem_en, .pll_buf_en, .rf_buf_en, .div1_en, .rf_div_en,
    .output_mute, .div_ratio, .manual_output_enable_mode, .osc_bias,
    .preset_cal);

  // ==========================================================
  // shared tasks
  task automatic chk(input string name, input logic [31:0] seen,
                     input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic timeout();
    err_total++;
    $display("bus wait ran out");
    end_sim();
  endtask

  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d,
                        output logic [1:0] resp);
    int n;
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) break;
    end
    resp = s_axi_bresp;
    if (n == 64) timeout();
  endtask

  task automatic axi_rd(input logic [31:0] a, output logic [31:0] d,
                        output logic [1:0] resp);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) break;
    end
    d = s_axi_rdata;
    resp = s_axi_rresp;
    if (n == 64) timeout();
  endtask

  // subaddress, then data that fires the forward
  task automatic fwd(input logic [3:0] sub, input logic [8:0] data);
    logic [1:0] r;
    axi_wr(vss_pkg::HOST_SUBADDR_OFF, {28'h0, sub}, r);
    chk("bresp sub", r, vss_pkg::RESP_OKAY);
    axi_wr(vss_pkg::HOST_DATA_OFF, {23'h0, data}, r);
    chk("bresp data", r, vss_pkg::RESP_OKAY);
    repeat (3) @(posedge aclk);
  endtask

  // ==========================================================
  // scenarios
  task automatic t_defaults();
    chk("tuning", tune9, 9'h020);
    chk("enables", en4, 4'hE);
    chk("ratio", div_ratio, 6'h01);
    chk("gains", {div_out_gain, rf_out_gain}, 3'h3);
    chk("config", cfg4[3:2], 2'h1);
    chk("rf bias", rf_buf_bias, 2'h2);
    $display("test defaults done");
  endtask

  task automatic t_walk();
    logic [31:0] d;
    logic [1:0] r;
    fwd(4'h1, 9'h01B);
    chk("walk en", {en4, output_mute}, 5'h1C);
    axi_rd(vss_pkg::HOST_DATA_OFF, d, r);
    chk("last data", d, 32'h0000_001B);
    axi_rd(vss_pkg::HOST_COUNT_OFF, d, r);
    chk("count", d, 32'h0000_0001);
    fwd(4'h1, 9'h01F);
    $display("test walk done");
  endtask

  task automatic t_tuning();
    logic [8:0] v[3] = '{9'h1FF, 9'h000, 9'h021};
    foreach (v[i]) begin
      fwd(4'h0, v[i]);
      chk("tuning", tune9, v[i]);
    end
    $display("test tuning done");
  endtask

  task automatic t_ratio();
    logic [5:0] rin[7] = '{6'd0, 6'd1, 6'd2, 6'd3, 6'd61, 6'd62, 6'd63};
    logic [5:0] rexp[7] = '{6'd0, 6'd1, 6'd2, 6'd2, 6'd60, 6'd62, 6'd62};
    logic [2:0] g;
    for (int i = 0; i < 7; i++) begin
      g = {i[0], i[1:0]};
      fwd(4'h2, {g, rin[i]});
      chk("ratio", div_ratio, rexp[i]);
      chk("auto en", en4,
          {1'b1, rexp[i] != 0, rexp[i] == 1, rexp[i] > 1});
      chk("gains", {div_out_gain, rf_out_gain}, g);
    end
    fwd(4'h2, 9'h0C1);
    $display("test ratio done");
  endtask

  task automatic t_manual();
    fwd(4'h3, 9'h055);
    chk("manual cfg", cfg4, 4'hE);
    fwd(4'h2, 9'h0C3);
    chk("man ratio 3", div_ratio, 6'd2);
    fwd(4'h2, 9'h0C1);
    chk("man ratio 1", div_ratio, 6'd0);
    fwd(4'h1, 9'h015);
    chk("man en", en4, 4'h5);
    fwd(4'h1, 9'h00B);
    chk("man en", en4, 4'hA);
    fwd(4'h1, 9'h01E);
    chk("man off", {subsystem_en, rf_buf_en, output_mute}, 3'h1);
    fwd(4'h3, 9'h040);
    chk("doubler", cfg4, 4'h0);
    chk("auto off", en4, 4'h0);
    fwd(4'h3, 9'h051);
    fwd(4'h1, 9'h01F);
    $display("test manual done");
  endtask

  task automatic t_presets();
    fwd(4'h4, 9'h13A);
    chk("bias", bias9, 9'h13A);
    fwd(4'h4, 9'h0C1);
    chk("bias", bias9, 9'h0C1);
    fwd(4'h5, 9'h02C);
    chk("cal freq", {cal_freq_high, cal_freq_mid_high, cal_freq_mid_low,
        cal_freq_low}, 8'h2C);
    fwd(4'h6, 9'h0A5);
    chk("msb cal", msb_cal, 8'hA5);
    fwd(4'h6, 9'h0FF);
    fwd(4'hE, 9'h000);
    chk("no reg 14", msb_cal, 8'hFF);
    $display("test presets done");
  endtask

  task automatic t_refused();
    logic [31:0] d;
    logic [1:0] r;
    axi_wr(32'h0000_0010, 32'h0000_0000, r);
    chk("wr unmapped", r, vss_pkg::RESP_SLVERR);
    axi_rd(32'h0000_001C, d, r);
    chk("rd data", d, 32'h0000_0000);
    chk("rd resp", r, vss_pkg::RESP_SLVERR);
    $display("test refused done");
  endtask

  // ==========================================================
  // clock, reset and sequence
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
    s_axi_wstrb = 4'hF;
    ce = 1'b1;
    err_total = 0;
    comparisons = 0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_defaults();
    t_walk();
    t_tuning();
    t_ratio();
    t_manual();
    t_presets();
    t_refused();
    end_sim();
  end
endmodule
